// file: design/shift_rotate_flag_unit.sv
// Shift, rotate, nibble swap and status flag datapath slice.
// Assumes requests come from core-clock logic and the register file
// writes back res.data when res.valid is high.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module shift_rotate_flag_unit (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  // Operation request
  input  wire srf_pkg::op_req_s req,
  // Result to register file
  output srf_pkg::op_res_s     res,
  // Status flags
  output logic [7:0]           status,
  // Register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic       valid_r;
  logic [7:0] count_r;
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // Shift results
  // ----------------------------------------------------------------
  wire logic [7:0] d     = req.operand;
  wire logic       c_old = status_r[srf_pkg::FLAG_C];
  wire logic       go    = req.valid;

  wire logic [7:0] lsl_res = {d[6:0], 1'b0};
  wire logic [7:0] lsr_res = {1'b0, d[7:1]};
  wire logic [7:0] rol_res = {d[6:0], c_old};
  wire logic [7:0] ror_res = {c_old, d[7:1]};
  wire logic [7:0] asr_res = {d[7], d[7:1]};
  wire logic [7:0] swp_res = {d[3:0], d[7:4]};

  wire logic is_left = (req.op == srf_pkg::OP_SHIFT_LEFT_ZERO_FILL) ||
                       (req.op == srf_pkg::OP_ROTATE_LEFT_VIA_CARRY);
  wire logic is_shift = is_left ||
    (req.op == srf_pkg::OP_SHIFT_RIGHT_ZERO_FILL) ||
    (req.op == srf_pkg::OP_ROTATE_RIGHT_VIA_CARRY) ||
    (req.op == srf_pkg::OP_SHIFT_RIGHT_SIGN_KEEP);

  logic [7:0] shift_res;
  always_comb begin
    unique case (req.op)
      srf_pkg::OP_SHIFT_LEFT_ZERO_FILL:   shift_res = lsl_res;
      srf_pkg::OP_SHIFT_RIGHT_ZERO_FILL:  shift_res = lsr_res;
      srf_pkg::OP_ROTATE_LEFT_VIA_CARRY:  shift_res = rol_res;
      srf_pkg::OP_ROTATE_RIGHT_VIA_CARRY: shift_res = ror_res;
      srf_pkg::OP_SHIFT_RIGHT_SIGN_KEEP:  shift_res = asr_res;
      default:                            shift_res = swp_res;
    endcase
  end

  // Carry out: bit 7 leaves on left moves, bit 0 on right moves
  wire logic sh_c = is_left ? d[7] : d[0];
  wire logic sh_n = shift_res[7];
  wire logic sh_z = (shift_res == 8'h00);
  wire logic sh_v = sh_n ^ sh_c;
  wire logic sh_s = sh_n ^ sh_v;

  // ----------------------------------------------------------------
  // Bit operations
  // ----------------------------------------------------------------
  wire logic [7:0] sel_mask = 8'h01 << req.sel;
  wire logic       t_old    = status_r[srf_pkg::FLAG_T];
  wire logic [7:0] bld_res  = t_old ? (d | sel_mask)
                                    : (d & ~sel_mask);
  wire logic       bst_bit  = d[req.sel];

  // ----------------------------------------------------------------
  // Next status and result
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    data_nxt   = data_r;
    if (go) begin
      unique case (req.op)
        srf_pkg::OP_SHIFT_LEFT_ZERO_FILL,
        srf_pkg::OP_SHIFT_RIGHT_ZERO_FILL,
        srf_pkg::OP_ROTATE_LEFT_VIA_CARRY,
        srf_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
        srf_pkg::OP_SHIFT_RIGHT_SIGN_KEEP: begin
          data_nxt                   = shift_res;
          status_nxt[srf_pkg::FLAG_C] = sh_c;
          status_nxt[srf_pkg::FLAG_Z] = sh_z;
          status_nxt[srf_pkg::FLAG_N] = sh_n;
          status_nxt[srf_pkg::FLAG_V] = sh_v;
          status_nxt[srf_pkg::FLAG_S] = sh_s;
        end
        srf_pkg::OP_NIBBLE_EXCHANGE: begin
          data_nxt = swp_res;
        end
        // Named flag raise/lower ops arrive as these with sel set
        srf_pkg::OP_STATUS_BIT_RAISE: begin
          status_nxt = status_r | sel_mask;
        end
        srf_pkg::OP_STATUS_BIT_LOWER: begin
          status_nxt = status_r & ~sel_mask;
        end
        srf_pkg::OP_COPY_BIT_TO_TRANSFER: begin
          status_nxt[srf_pkg::FLAG_T] = bst_bit;
        end
        srf_pkg::OP_COPY_TRANSFER_TO_BIT: begin
          data_nxt = bld_res;
        end
        default: begin
          status_nxt = status_r;
        end
      endcase
    end else if (reg_wr && reg_addr == srf_pkg::ADDR_STATUS) begin
      // Software write loses to a same-cycle operation
      status_nxt = reg_wdata;
    end
  end

  wire logic writes_data = go && (is_shift ||
    req.op == srf_pkg::OP_NIBBLE_EXCHANGE ||
    req.op == srf_pkg::OP_COPY_TRANSFER_TO_BIT);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= srf_pkg::STATUS_RESET;
      data_r   <= srf_pkg::RESULT_RESET;
      valid_r  <= 1'b0;
    end else begin
      status_r <= status_nxt;
      data_r   <= data_nxt;
      valid_r  <= writes_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 8'h00;
    end else if (reg_wr && reg_addr == srf_pkg::ADDR_OPCOUNT) begin
      count_r <= 8'h00;
    end else if (go) begin
      count_r <= count_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      srf_pkg::ADDR_STATUS:  rd_mux = status_r;
      srf_pkg::ADDR_RESULT:  rd_mux = data_r;
      srf_pkg::ADDR_OPCOUNT: rd_mux = count_r;
      default:               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign res.valid = valid_r;
  assign res.data  = data_r;
  assign status    = status_r;
  assign reg_rdata = rdata_r;

endmodule : shift_rotate_flag_unit

// file: design/srf_pkg.sv
// Constants, opcodes and carriers for the shift, rotate and flag unit.
// Assumes one core clock; operands arrive from the working register file.
//
// Summary of operation
// - Shift left: bits move up, zero into bit 0, flags Z C N V S, one cycle.
// - Shift right: bits move down, zero into bit 7, flags Z C N V S.
// - Rotate left through carry: old C to bit 0, bit 7 to C.
// - Rotate right through carry: old C to bit 7, bit 0 to C.
// - Arithmetic shift right: bit 7 kept, others shift down, flags Z C N V S.
// - Nibble swap in one cycle, no flag changes.
// - Status bit raise or lower writes only the bit selected by s.
// - Copy source bit b into transfer bit, no other flag changes.
// - Copy transfer bit into destination bit b, other bits and flags kept.
// - Carry raise sets C, carry lower clears C, one cycle.
// - Negative raise sets N, negative lower clears N.
// - Zero raise sets Z, zero lower clears Z.
// - Interrupt enable on sets I, off clears I.
// - Sign raise sets S, sign lower clears S.
// - Overflow raise sets V, overflow lower clears V.
// - Transfer raise sets T, transfer lower clears T.
// - Half carry raise sets H, lower clears H, one cycle.
package srf_pkg;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // ----------------------------------------------------------------
  // Reset values and register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_RESULT   = 4'h1;
  localparam logic [3:0] ADDR_OPCOUNT  = 4'h2;
  localparam int unsigned OP_CYCLES    = 1;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_SHIFT_LEFT_ZERO_FILL,
    OP_SHIFT_RIGHT_ZERO_FILL,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_SHIFT_RIGHT_SIGN_KEEP,
    OP_NIBBLE_EXCHANGE,
    OP_STATUS_BIT_RAISE,
    OP_STATUS_BIT_LOWER,
    OP_COPY_BIT_TO_TRANSFER,
    OP_COPY_TRANSFER_TO_BIT
  } op_e;

  // Request from the decoder; flag raise/lower by name map onto bit ops
  typedef struct packed {
    logic       valid;
    op_e        op;
    logic [7:0] operand;
    logic [2:0] sel;
  } op_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } op_res_s;

endpackage : srf_pkg

// file: verif/shift_rotate_flag_unit_properties.sv
// Concurrent checks on the ports of the shift, rotate and flag unit.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module shift_rotate_flag_unit_properties (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             reset_n,
  // Operation, result and flags
  input wire srf_pkg::op_req_s req,
  input wire srf_pkg::op_res_s res,
  input wire logic [7:0]       status,
  // Register port
  input wire logic [3:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic [3:0] o = req.op;
  wire logic       v = req.valid;
  // Shift ops sit in one contiguous block of the opcode list
  wire logic       sh = v && o >= 4'h1 && o <= 4'h5;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_shl;
    v && o == 4'h1 |=> res.valid && res.data == ($past(req.operand) << 1)
      && status[0] == $past(req.operand[7]);
  endproperty
  a_shl: assert property (p_shl) else $error("shift left wrong");
  property p_rol;
    v && o == 4'h3 |=> res.data == {$past(req.operand[6:0]), $past(status[0])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");
  property p_asr;
    v && o == 4'h5 |=> res.data[7] == $past(req.operand[7])
      && status[0] == $past(req.operand[0]);
  endproperty
  a_asr: assert property (p_asr) else $error("sign shift wrong");
  property p_swap;
    v && o == 4'h6 |=> $stable(status)
      && res.data == {$past(req.operand[3:0]), $past(req.operand[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_flags;
    sh |=> status[2] == res.data[7] && status[1] == (res.data == 8'h00)
      && status[3] == (status[2] ^ status[0])
      && status[4] == (status[2] ^ status[3]);
  endproperty
  a_flags: assert property (p_flags) else $error("shift flags wrong");
  property p_raise;
    v && o == 4'h7 |=> status == ($past(status) | (8'h01 << $past(req.sel)));
  endproperty
  a_raise: assert property (p_raise) else $error("raise wrong");
  property p_lower;
    v && o == 4'h8 |=> status == ($past(status) & ~(8'h01 << $past(req.sel)));
  endproperty
  a_lower: assert property (p_lower) else $error("lower wrong");
  property p_rdv;
    res.valid |-> $past(req.valid);
  endproperty
  a_rdv: assert property (p_rdv) else $error("stray result");
  property p_rd;
    reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(status);
  endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
endmodule : shift_rotate_flag_unit_properties

// file: verif/shift_rotate_flag_unit_bench.sv
// Self-checking bench for the shift, rotate and flag unit.
// Assumes the register port map chosen in the design package.
`timescale 1ns/1ns
module shift_rotate_flag_unit_bench;
  // ----------------------------------------------------------------
  // Signals and case table
  // ----------------------------------------------------------------
  logic             sys_clk;
  logic             reset_n;
  srf_pkg::op_req_s req;
  srf_pkg::op_res_s res;
  logic [7:0]       status;
  logic [3:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic [7:0]       v;
  int               errors = 0;
  int               n_tests = 0;
  int               cyc = 0;
  logic [3:0]       t_op [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
  logic [7:0]       t_in [6] = '{8'he0, 8'h00, 8'h01, 8'h01, 8'h00, 8'ha5};
  logic [7:0]       t_d  [6] = '{8'h81, 8'h01, 8'h80, 8'h01, 8'h82, 8'h3c};
  logic [7:0]       t_r  [6] = '{8'h02, 8'h00, 8'h01, 8'h80, 8'hc1, 8'hc3};
  logic [7:0]       t_s  [6] = '{8'hf9, 8'h1b, 8'h19, 8'h15, 8'h0c, 8'ha5};
  shift_rotate_flag_unit u_shift_rotate_flag_unit (
    .sys_clk(sys_clk), .reset_n(reset_n), .req(req), .res(res),
    .status(status), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task op(input logic [3:0] o, input logic [7:0] d, input logic [2:0] s);
    @(posedge sys_clk);
    req <= '{1'b1, srf_pkg::op_e'(o), d, s};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
  endtask : op
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // ----------------------------------------------------------------
  // Sequence; a hang is cut short well past the expected run
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      errors++;
      summarize();
    end
  end
  initial begin
    req = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    chk(status, 8'h00);
    v = 8'h00;
    for (int i = 0; i < 16; i++) begin
      op(i < 8 ? 4'h7 : 4'h8, 8'hff, i[2:0]);
      v[i[2:0]] = (i < 8);
      chk(status, v);
    end
    for (int i = 0; i < 6; i++) begin
      wr(4'h0, t_in[i]);
      op(t_op[i], t_d[i], 3'h0);
      chk(res.data, t_r[i]);
      chk(status, t_s[i]);
    end
    wr(4'h0, 8'h00);
    op(4'h9, 8'h08, 3'h3);
    chk(status, 8'h40);
    op(4'ha, 8'h81, 3'h5);
    chk(res.data, 8'ha1);
    rd(4'h0, v);
    chk(v, 8'h40);
    rd(4'hf, v);
    chk(v, 8'h00);
    rd(4'h1, v);
    chk(v, 8'ha1);
    rd(4'h2, v);
    chk(v, 8'h18);
    wr(4'h2, 8'h00);
    rd(4'h2, v);
    chk(v, 8'h00);
    summarize();
  end
endmodule : shift_rotate_flag_unit_bench
bind shift_rotate_flag_unit shift_rotate_flag_unit_properties u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .req(req), .res(res),
  .status(status), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
